/* verilog/ptx_regs.svh */
// Function
// - Data path is 64 bits, or 64 or 128 bits on four- and eight-lane builds.
// - Data path width is fixed at build time, never changed by link speed.
// - TLAST marks a packet's final beat and counts only with TVALID high.
// - Core raises TREADY when able; one beat moves per cycle both high.
// - Strobe bit n qualifies byte lane n, bit 0 the lowest byte.
// - Core reports the number of free transmit buffers on six bits.
// - Each buffer holds one whole packet up to the maximum payload size.
// - Core flags a drop on length violation or a gap in a streamed packet.
// - A streamed packet may be launched before it is wholly written.
// - Core requests the port when its own packet is ready to send.
// - One grant while requesting makes the core's packet next; it is remembered.
`ifndef PTX_REGS_SVH
`define PTX_REGS_SVH

// Register byte addresses
`define PTX_CTRL_ADDR     8'h00
`define PTX_MAXBEAT_ADDR  8'h04
`define PTX_STATUS_ADDR   8'h08
`define PTX_DROPCNT_ADDR  8'h0c

// Control fields
`define PTX_CTRL_EN_BIT    0
`define PTX_CTRL_GNT_BIT   1
`define PTX_CTRL_RESET     2'h0

// Status fields
`define PTX_STAT_FREE_LSB  0
`define PTX_STAT_BUSY_BIT  8
`define PTX_STAT_REQ_BIT   9
`define PTX_STAT_HELD_BIT  10

// Sideband bit positions
`define PTX_TU_ECRC        0
`define PTX_TU_POISON      1
`define PTX_TU_STREAM      2
`define PTX_TU_DISCONT     3

// Defaults: 512-byte payload plus header in 8-byte beats
`define PTX_MAXBEAT_RESET  10'h044
`define PTX_NUM_BUFS       6'h20

`endif

/* verilog/ptx_pkg.sv */
package ptx_pkg;
	typedef enum logic [1:0] {
		PTX_IDLE    = 2'b00,
		PTX_PKT     = 2'b01,
		PTX_DISCARD = 2'b10
	} ptx_state_t;

	typedef enum logic [1:0] {
		PTX_HT_IDLE   = 2'b00,
		PTX_HT_BUSY   = 2'b01,
		PTX_HT_NONSEQ = 2'b10,
		PTX_HT_SEQ    = 2'b11
	} ptx_htrans_t;
endpackage : ptx_pkg

/* verilog/ptx_free_count.sv */
`timescale 1ns/1ps
module ptx_free_count #(
	parameter int NUM_BUFS = 32
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       arst_n,
	// Events
	input  wire logic       take,
	input  wire logic       give_link,
	input  wire logic       give_drop,
	// Count
	output logic      [5:0] count,
	output logic      [5:0] next_count
);
	localparam logic [5:0] FULL = 6'(NUM_BUFS);

	initial begin
		if (NUM_BUFS < 1 || NUM_BUFS > 63)
			$error("NUM_BUFS must lie in 1..63");
	end

	// A release beyond the total is ignored so the count never overstates
	always_comb begin
		next_count = count;
		if (take && next_count != 6'h00)
			next_count = next_count - 6'h01;
		if (give_link && next_count != FULL)
			next_count = next_count + 6'h01;
		if (give_drop && next_count != FULL)
			next_count = next_count + 6'h01;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			count <= FULL;
		else
			count <= next_count;
	end
endmodule : ptx_free_count

/* verilog/ptx_pkt_check.sv */
`timescale 1ns/1ps
module ptx_pkt_check #(
	parameter int DATA_W = 64
) (
	// Beat under test
	input  wire logic [DATA_W/8-1:0] strb,
	input  wire logic                last,
	input  wire logic [9:0]          beat_idx,
	input  wire logic [9:0]          max_beats,
	// Verdicts
	output logic                     strb_bad,
	output logic                     len_bad
);
	localparam int SW = DATA_W / 8;

	// Legal strobes fill all lanes, or on the last beat whole dwords from lane 0 upward
	function automatic logic strb_legal(input logic [SW-1:0] s, input logic l);
		logic ok;
		ok = (s == {SW{1'b1}});
		if (l) begin
			for (int k = 1; k <= SW / 4; k++)
				if (s == SW'((1 << (4 * k)) - 1))
					ok = 1'b1;
		end
		return ok;
	endfunction : strb_legal

	always_comb begin
		strb_bad = !strb_legal(strb, last);
		len_bad  = (beat_idx >= max_beats);
	end
endmodule : ptx_pkt_check

/* verilog/ptx_tx_port.sv */
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ptx_regs.svh"
module ptx_tx_port #(
	parameter int DATA_W   = 64,
	parameter int NUM_BUFS = 32
) (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     arst_n,
	// AHB-Lite slave
	input  wire logic                     hsel,
	input  wire logic [7:0]               haddr,
	input  wire ptx_pkg::ptx_htrans_t     htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic      [31:0]              hrdata,
	// User transmit stream
	input  wire logic [DATA_W-1:0]        s_axis_tx_tdata,
	input  wire logic [DATA_W/8-1:0]      s_axis_tx_tstrb,
	input  wire logic                     s_axis_tx_tvalid,
	input  wire logic                     s_axis_tx_tlast,
	input  wire logic [3:0]               s_axis_tx_tuser,
	output logic                          s_axis_tx_tready,
	// Buffer status and drops
	output logic      [5:0]               free_buffer_count,
	output logic                          tx_terr_drop,
	// Internal packet arbitration
	input  wire logic                     tx_cfg_gnt,
	output logic                          tx_cfg_req,
	// Core side: internal packet source
	input  wire logic                     cfg_pkt_pending,
	output logic                          cfg_pkt_take,
	// Core side: link engine
	input  wire logic                     link_buf_release,
	output logic      [DATA_W-1:0]        link_data,
	output logic      [DATA_W/8-1:0]      link_strb,
	output logic                          link_valid,
	output logic                          link_last,
	output logic      [3:0]               link_flags,
	output logic                          link_launch,
	output logic                          link_abort
);
	import ptx_pkg::*;

	initial begin
		if (DATA_W != 64 && DATA_W != 128)
			$error("DATA_W must be 64 or 128");
	end

	ptx_state_t  state;
	ptx_state_t  next_state;
	logic [1:0]  ctrl;
	logic [9:0]  max_beats;
	logic [15:0] drop_cnt;
	logic [9:0]  beat_idx;
	logic        pkt_stream;
	logic        gnt_held;
	logic [5:0]  next_free;
	logic        strb_bad;
	logic        len_bad;

	// Bus address phase
	logic        ph_wr;
	logic [7:0]  ph_addr;

	wire logic accept  = s_axis_tx_tvalid && s_axis_tx_tready;
	wire logic eof     = accept && s_axis_tx_tlast;
	wire logic sof     = accept && (state == PTX_IDLE);
	wire logic viol    = accept && (strb_bad || len_bad);
	wire logic gap     = (state == PTX_PKT) && pkt_stream && !s_axis_tx_tvalid;
	wire logic gnt_any = gnt_held || ctrl[`PTX_CTRL_GNT_BIT];
	wire logic cfg_go  = (state == PTX_IDLE) && !s_axis_tx_tready && gnt_any
		&& cfg_pkt_pending && tx_cfg_req && (free_buffer_count != 6'h00);
	wire logic drop_ev = eof && ((state == PTX_DISCARD) || viol);
	wire logic ph_go   = hsel && hready && htrans[1];

	ptx_pkt_check #(
		.DATA_W    (DATA_W)
	) u_check (
		.strb      (s_axis_tx_tstrb),
		.last      (s_axis_tx_tlast),
		.beat_idx  (beat_idx),
		.max_beats (max_beats),
		.strb_bad  (strb_bad),
		.len_bad   (len_bad)
	);

	ptx_free_count #(
		.NUM_BUFS   (NUM_BUFS)
	) u_free (
		.mclk       (mclk),
		.arst_n     (arst_n),
		.take       (sof || cfg_go),
		.give_link  (link_buf_release),
		.give_drop  (drop_ev),
		.count      (free_buffer_count),
		.next_count (next_free)
	);

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			`PTX_CTRL_ADDR:    v[1:0] = ctrl;
			`PTX_MAXBEAT_ADDR: v[9:0] = max_beats;
			`PTX_STATUS_ADDR: begin
				v[`PTX_STAT_FREE_LSB +: 6] = free_buffer_count;
				v[`PTX_STAT_BUSY_BIT]      = (state != PTX_IDLE);
				v[`PTX_STAT_REQ_BIT]       = tx_cfg_req;
				v[`PTX_STAT_HELD_BIT]      = gnt_held;
			end
			`PTX_DROPCNT_ADDR: v[15:0] = drop_cnt;
			default:           v = 32'h0000_0000;
		endcase
		return v;
	endfunction : reg_read

	// Packet state
	always_comb begin
		next_state = state;
		case (state)
			PTX_IDLE: begin
				if (accept && !s_axis_tx_tlast)
					next_state = viol ? PTX_DISCARD : PTX_PKT;
			end
			PTX_PKT: begin
				if (gap || (viol && !s_axis_tx_tlast))
					next_state = PTX_DISCARD;
				else if (eof)
					next_state = PTX_IDLE;
			end
			PTX_DISCARD: begin
				if (eof)
					next_state = PTX_IDLE;
			end
			default: next_state = PTX_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			state <= PTX_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			beat_idx   <= 10'h000;
			pkt_stream <= 1'b0;
		end else begin
			if (eof)
				beat_idx <= 10'h000;
			else if (accept && beat_idx != 10'h3ff)
				beat_idx <= beat_idx + 10'h001;
			if (sof)
				pkt_stream <= s_axis_tx_tuser[`PTX_TU_STREAM];
		end
	end

	// Ready is registered; mid-packet it stays high so a packet always completes
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			s_axis_tx_tready <= 1'b0;
		else if (next_state != PTX_IDLE)
			s_axis_tx_tready <= 1'b1;
		else
			s_axis_tx_tready <= ctrl[`PTX_CTRL_EN_BIT] && (next_free != 6'h00)
				&& !((gnt_any || (tx_cfg_gnt && tx_cfg_req)) && cfg_pkt_pending
				&& !cfg_go);
	end

	// Internal packet request and remembered grant
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_cfg_req   <= 1'b0;
			gnt_held     <= 1'b0;
			cfg_pkt_take <= 1'b0;
		end else begin
			tx_cfg_req   <= cfg_pkt_pending && !cfg_go && !cfg_pkt_take;
			gnt_held     <= (tx_cfg_gnt && tx_cfg_req) || (gnt_held && !cfg_go);
			cfg_pkt_take <= cfg_go;
		end
	end

	// Link side: beats pass on one cycle later; launch marks when sending may start
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			link_data   <= '0;
			link_strb   <= '0;
			link_valid  <= 1'b0;
			link_last   <= 1'b0;
			link_flags  <= 4'h0;
			link_launch <= 1'b0;
			link_abort  <= 1'b0;
		end else begin
			link_valid  <= accept && (state != PTX_DISCARD) && !viol;
			link_data   <= s_axis_tx_tdata;
			link_strb   <= s_axis_tx_tstrb;
			link_last   <= s_axis_tx_tlast;
			link_flags  <= s_axis_tx_tuser;
			link_launch <= accept && !viol && (state != PTX_DISCARD)
				&& ((sof && s_axis_tx_tuser[`PTX_TU_STREAM])
				|| (s_axis_tx_tlast && !pkt_stream && !sof)
				|| (sof && s_axis_tx_tlast));
			link_abort  <= (state == PTX_PKT) && (gap || viol);
		end
	end

	// Drop pulse comes once, the cycle after the discarded packet's last beat
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			tx_terr_drop <= 1'b0;
		else
			tx_terr_drop <= drop_ev;
	end

	// AHB-Lite slave: zero wait states, always OKAY
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			ph_wr     <= 1'b0;
			ph_addr   <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			ph_wr     <= ph_go && hwrite;
			ph_addr   <= haddr;
			if (ph_go && !hwrite)
				hrdata <= reg_read({haddr[7:2], 2'b00});
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl      <= `PTX_CTRL_RESET;
			max_beats <= `PTX_MAXBEAT_RESET;
		end else if (ph_wr) begin
			if (ph_addr[7:2] == `PTX_CTRL_ADDR >> 2)
				ctrl <= hwdata[1:0];
			if (ph_addr[7:2] == `PTX_MAXBEAT_ADDR >> 2)
				max_beats <= hwdata[9:0];
		end
	end

	// A write clears the counter, but a drop in the same cycle still counts
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			drop_cnt <= 16'h0000;
		else if (ph_wr && ph_addr[7:2] == `PTX_DROPCNT_ADDR >> 2)
			drop_cnt <= {15'h0000, drop_ev};
		else if (drop_ev && drop_cnt != 16'hffff)
			drop_cnt <= drop_cnt + 16'h0001;
	end

	a_ready_no_buffer: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == PTX_IDLE && free_buffer_count == 6'h00) |-> !s_axis_tx_tready)
		else $error("ready high with no free buffer");
	a_drop_one_cycle: assert property (@(posedge mclk) disable iff (!arst_n)
		tx_terr_drop |=> !tx_terr_drop)
		else $error("drop pulse longer than one cycle");
	a_gap_discards: assert property (@(posedge mclk) disable iff (!arst_n)
		gap |=> (state == PTX_DISCARD) && link_abort)
		else $error("streamed gap not discarded");
	a_beat_forward: assert property (@(posedge mclk) disable iff (!arst_n)
		(accept && state != PTX_DISCARD && !viol)
		|=> link_valid && link_data == $past(s_axis_tx_tdata))
		else $error("accepted beat not forwarded");
	a_strb_full_mid: assert property (@(posedge mclk) disable iff (!arst_n)
		(link_valid && !link_last) |-> (&link_strb))
		else $error("partial strobe forwarded mid packet");
	a_len_drop: assert property (@(posedge mclk) disable iff (!arst_n)
		(eof && len_bad) |=> tx_terr_drop ##1 !tx_terr_drop)
		else $error("length violation not dropped");
	a_take_needs_gnt: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(cfg_pkt_take) |-> $past(gnt_any) && $past(free_buffer_count) != 6'h00)
		else $error("internal packet taken without grant");
	a_grant_blocks: assert property (@(posedge mclk) disable iff (!arst_n)
		(gnt_held && cfg_pkt_pending && next_state == PTX_IDLE && !cfg_go)
		|=> !s_axis_tx_tready)
		else $error("user packet passed a granted internal packet");
	a_req_follows: assert property (@(posedge mclk) disable iff (!arst_n)
		(cfg_pkt_pending && !cfg_go && !cfg_pkt_take) |=> tx_cfg_req)
		else $error("request missing while internal packet pending");
	a_cut_through: assert property (@(posedge mclk) disable iff (!arst_n)
		(sof && !viol && s_axis_tx_tuser[`PTX_TU_STREAM]) |=> link_launch)
		else $error("streamed packet not launched at first beat");
	a_free_bound: assert property (@(posedge mclk) disable iff (!arst_n)
		free_buffer_count <= 6'(NUM_BUFS))
		else $error("free count above buffer total");

	c_drop:     cover property (@(posedge mclk) disable iff (!arst_n) tx_terr_drop);
	c_cfg_take: cover property (@(posedge mclk) disable iff (!arst_n) cfg_pkt_take);
	c_stream:   cover property (@(posedge mclk) disable iff (!arst_n) eof && pkt_stream);
	c_gap:      cover property (@(posedge mclk) disable iff (!arst_n) gap);
endmodule : ptx_tx_port

/* tb/ptx_user_src.sv */
`timescale 1ns/1ps
module ptx_user_src #(
	parameter int DATA_W = 64
) (
	// Clock and handshake
	input  wire logic                mclk,
	input  wire logic                tready,
	// Stream towards the core
	output logic      [DATA_W-1:0]   tdata,
	output logic      [DATA_W/8-1:0] tstrb,
	output logic                     tvalid,
	output logic                     tlast,
	output logic      [3:0]          tuser
);
	initial begin
		tdata  = '0;
		tstrb  = '0;
		tvalid = 1'b0;
		tlast  = 1'b0;
		tuser  = 4'h0;
	end

	// A gap index above zero drops valid for one cycle before that beat
	task automatic send(input int nb, input logic [DATA_W/8-1:0] ls, input logic [3:0] u,
		input int gap);
		for (int i = 0; i < nb; i++) begin
			if (gap != 0 && i == gap) begin
				tvalid <= 1'b0;
				tdata  <= ~tdata;
				@(posedge mclk);
			end
			tvalid <= 1'b1;
			tdata  <= {(DATA_W/8){8'h10 + 8'(i)}};
			tlast  <= (i == nb - 1);
			tstrb  <= (i == nb - 1) ? ls : '1;
			tuser  <= {u[3] && i == nb - 1 && i > 0, u[2], u[1], u[0] && i == 0};
			do @(posedge mclk); while (tready !== 1'b1);
		end
		tvalid <= 1'b0;
		tlast  <= 1'b0;
		tdata  <= ~tdata; // Released bus must not keep the last beat
	endtask : send
endmodule : ptx_user_src

/* tb/pcie_tlp_transmit_user_port_bench.sv */
`timescale 1ns/1ps
`include "ptx_regs.svh"
module pcie_tlp_transmit_user_port_bench;
	import ptx_pkg::*;
	typedef struct {
		int         nb;
		logic [7:0] ls;
		logic [3:0] u;
		logic       drop;
	} ptx_row_t;
	logic        mclk, arst_n, hsel, hwrite, hreadyout, hresp, tvalid, tlast, tready;
	logic        tx_cfg_gnt, tx_cfg_req, cfg_pkt_pending, cfg_pkt_take, link_buf_release;
	logic        link_valid, link_last, link_launch, link_abort, tx_terr_drop, took;
	logic [7:0]  haddr, tstrb, link_strb, ls_seen;
	ptx_htrans_t htrans;
	logic [31:0] hwdata, hrdata, rd;
	logic [63:0] tdata, link_data, d0;
	logic [3:0]  tuser, link_flags, fl_seen;
	logic [5:0]  free_buffer_count;
	int          n_fail, check_count, nbeat, drops, aborts, launch_at;
	ptx_row_t    rows [6] = '{'{2, 8'hff, 4'h0, 1'b0}, '{1, 8'h0f, 4'h1, 1'b0},
		'{3, 8'hff, 4'h2, 1'b0}, '{2, 8'h3f, 4'h0, 1'b1}, '{2, 8'h0f, 4'h4, 1'b0},
		'{3, 8'hff, 4'h8, 1'b0}};

	ptx_tx_port #(.DATA_W(64), .NUM_BUFS(32)) dut (
		.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.s_axis_tx_tdata(tdata), .s_axis_tx_tstrb(tstrb), .s_axis_tx_tvalid(tvalid),
		.s_axis_tx_tlast(tlast), .s_axis_tx_tuser(tuser), .s_axis_tx_tready(tready),
		.free_buffer_count(free_buffer_count), .tx_terr_drop(tx_terr_drop),
		.tx_cfg_gnt(tx_cfg_gnt), .tx_cfg_req(tx_cfg_req), .cfg_pkt_pending(cfg_pkt_pending),
		.cfg_pkt_take(cfg_pkt_take), .link_buf_release(link_buf_release),
		.link_data(link_data), .link_strb(link_strb), .link_valid(link_valid),
		.link_last(link_last), .link_flags(link_flags), .link_launch(link_launch),
		.link_abort(link_abort));

	ptx_user_src #(.DATA_W(64)) src (.mclk(mclk), .tready(tready), .tdata(tdata),
		.tstrb(tstrb), .tvalid(tvalid), .tlast(tlast), .tuser(tuser));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Link side observer: counts what leaves the core
	always @(posedge mclk) begin
		if (link_valid === 1'b1 && nbeat == 0)
			d0 = link_data;
		if (link_valid === 1'b1)
			nbeat++;
		if (link_launch === 1'b1)
			launch_at = nbeat;
		if (link_last === 1'b1) begin
			ls_seen = link_strb;
			fl_seen = link_flags;
		end
		if (tx_terr_drop === 1'b1)
			drops++;
		if (link_abort === 1'b1)
			aborts++;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Zero-wait slave, but the master still waits on hready each phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= PTX_HT_NONSEQ;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= PTX_HT_IDLE;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic release_buf();
		link_buf_release <= 1'b1;
		@(posedge mclk);
		link_buf_release <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : release_buf

	// With grant-always set the take follows the request with no grant pulse
	task automatic arb(input logic g);
		cfg_pkt_pending <= 1'b1;
		for (int i = 0; i < 20 && tx_cfg_req !== 1'b1; i++)
			@(posedge mclk);
		chk("cfg request", 32'h1, tx_cfg_req);
		if (g) begin
			tx_cfg_gnt <= 1'b1;
			@(posedge mclk);
			tx_cfg_gnt <= 1'b0;
		end
		took = 1'b0;
		for (int i = 0; i < 10 && !took; i++) begin
			@(posedge mclk);
			took = (cfg_pkt_take === 1'b1);
		end
		cfg_pkt_pending <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("cfg take", 32'h1, took);
		chk("cfg buffer", 32'd31, free_buffer_count);
		release_buf();
	endtask : arb

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	initial begin
		#125000;
		n_fail++;
		print_verdict();
	end

	initial begin
		{arst_n, hsel, hwrite, tx_cfg_gnt, cfg_pkt_pending, link_buf_release} = '0;
		{haddr, hwdata, n_fail, check_count, nbeat, drops, aborts} = '0;
		htrans = PTX_HT_IDLE;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		chk("free at reset", 32'd32, free_buffer_count);
		chk("tready before enable", 32'h0, tready);
		ahb(1'b0, `PTX_MAXBEAT_ADDR, 32'h0);
		chk("maxbeat reset", {22'h0, `PTX_MAXBEAT_RESET}, rd);
		ahb(1'b0, `PTX_STATUS_ADDR, 32'h0);
		chk("status idle", {26'h0, `PTX_NUM_BUFS}, rd);
		ahb(1'b0, 8'h10, 32'h0);
		chk("unmapped read", 32'h0, rd);
		chk("hresp", 32'h0, hresp);
		ahb(1'b1, `PTX_CTRL_ADDR, 32'h1);
		$display("test reset and registers done");
		foreach (rows[r]) begin
			{nbeat, drops, launch_at} = '0;
			src.send(rows[r].nb, rows[r].ls, rows[r].u, 0);
			repeat (4) @(posedge mclk);
			chk("drop pulses", rows[r].drop, drops);
			if (!rows[r].drop) begin
				chk("beats", rows[r].nb, nbeat);
				chk("last strobe", rows[r].ls, ls_seen);
				chk("first data", 32'h10101010, d0[31:0]);
				chk("free held", 32'd31, free_buffer_count);
				chk("launch beat", rows[r].u[`PTX_TU_STREAM] ? 1 : rows[r].nb, launch_at);
				chk("last flags", {rows[r].u[3] && rows[r].nb > 1, rows[r].u[2:1],
					rows[r].u[0] && rows[r].nb == 1}, fl_seen);
				release_buf();
			end
			chk("free back", 32'd32, free_buffer_count);
			$display("test row %0d done", r);
		end
		ahb(1'b1, `PTX_MAXBEAT_ADDR, 32'h2);
		drops = 0;
		src.send(3, 8'hff, 4'h0, 0);
		repeat (4) @(posedge mclk);
		chk("length drop", 32'd1, drops);
		ahb(1'b1, `PTX_MAXBEAT_ADDR, 32'h44);
		$display("test length violation done");
		{drops, aborts} = '0;
		src.send(3, 8'hff, 4'h4, 1);
		repeat (4) @(posedge mclk);
		chk("gap abort", 32'd1, aborts);
		chk("gap drop", 32'd1, drops);
		ahb(1'b0, `PTX_DROPCNT_ADDR, 32'h0);
		chk("drop count", 32'd3, rd & 32'hffff);
		$display("test streamed gap done");
		arb(1'b1);
		ahb(1'b1, `PTX_CTRL_ADDR, 32'h3);
		arb(1'b0);
		$display("test arbitration done");
		src.send(2, 8'hff, 4'h0, 0);
		repeat (2) @(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		chk("free after reset", 32'd32, free_buffer_count);
		chk("tready after reset", 32'h0, tready);
		ahb(1'b0, `PTX_CTRL_ADDR, 32'h0);
		chk("ctrl after reset", 32'h0, rd);
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule : pcie_tlp_transmit_user_port_bench
